//--- pkg/vsk_consts.svh
`ifndef VSK_CONSTS_SVH
`define VSK_CONSTS_SVH

// register offsets on the mmio port
`define VSK_OFF_SIZE      20'h72190
`define VSK_OFF_KEY_MIN   20'h72194
`define VSK_OFF_KEY_MASK  20'h72198
`define VSK_OFF_SURF      20'h7219C
`define VSK_OFF_KEY_MAX   20'h721A0
`define VSK_OFF_TILE      20'h721A4
`define VSK_OFF_STATUS    20'h721C0

// writable bits of each register, reserved bits read as zero
`define VSK_MASK_SIZE     32'h0FFF0FFF
`define VSK_MASK_KEY_MIN  32'h00FFFFFF
`define VSK_MASK_KEY_MSK  32'h07FFFFFF
`define VSK_MASK_SURF     32'hFFFFF000
`define VSK_MASK_KEY_MAX  32'h00FFFFFF
`define VSK_MASK_TILE     32'h0FFF0FFF

// field positions
`define VSK_SRC_EN_LSB    24
`define VSK_HI_MSB        27
`define VSK_HI_LSB        16
`define VSK_LO_MSB        11
`define VSK_LO_LSB        0
`define VSK_PAGE_LSB      12

// reset values
`define VSK_RST_REG       32'h00000000

`endif

//--- pkg/vsk_pkg.sv
`default_nettype none
package vsk_pkg;

    // one pixel: V/red, Y/green, U/blue
    typedef struct packed {
        logic [7:0] v;
        logic [7:0] y;
        logic [7:0] u;
    } vsk_pix_s;

    // one copy of the double-buffered register set
    typedef struct packed {
        logic [31:0] size;
        logic [31:0] key_min;
        logic [31:0] key_mask;
        logic [31:0] surf;
        logic [31:0] key_max;
        logic [31:0] tile;
    } vsk_regs_s;

    typedef enum logic [1:0] {
        VSK_KEY_OFF,
        VSK_KEY_SRC,
        VSK_KEY_DST
    } vsk_key_mode_e;

endpackage
`default_nettype wire

//--- verilog/vsk_key_unit.sv
`default_nettype none
`include "vsk_consts.svh"
module vsk_key_unit (
    input  wire vsk_pkg::vsk_key_mode_e mode,        // keying function in use
    input  wire logic [31:0]            key_min,     // key value / minimum
    input  wire logic [31:0]            key_mask,    // channel enables and bit masks
    input  wire logic [31:0]            key_max,     // range maximum
    input  wire vsk_pkg::vsk_pix_s      sprite_pix,  // sprite pixel
    input  wire vsk_pkg::vsk_pix_s      primary_pix, // primary plane pixel
    output logic                        src_hit,     // sprite pixel inside key range
    output logic                        dst_hit,     // primary pixel matches key
    output vsk_pkg::vsk_pix_s           out_pix      // selected pixel
);
    logic [2:0]  chan_ok;
    logic [23:0] diff;

    // per channel inclusive range check, skipped where disabled
    for (genvar c = 0; c < 3; c++)
    begin : g_chan
        logic [7:0] pv;
        logic [7:0] lo;
        logic [7:0] hi;
        assign pv = sprite_pix[c*8 +: 8];
        assign lo = key_min[c*8 +: 8];
        assign hi = key_max[c*8 +: 8];
        assign chan_ok[c] = !key_mask[`VSK_SRC_EN_LSB + c] || ((pv >= lo) && (pv <= hi));
    end

    assign diff = (primary_pix ^ key_min[23:0]) & key_mask[23:0];

    always_comb
    begin
        src_hit = (mode == vsk_pkg::VSK_KEY_SRC) && (&chan_ok);
        dst_hit = (mode == vsk_pkg::VSK_KEY_DST) && (diff == 24'h000000);
        case (mode)
            vsk_pkg::VSK_KEY_DST: out_pix = dst_hit ? sprite_pix : primary_pix;
            vsk_pkg::VSK_KEY_SRC: out_pix = src_hit ? primary_pix : sprite_pix;
            default:              out_pix = sprite_pix;
        endcase
    end

endmodule
`default_nettype wire

//--- verilog/vsk_sprite_regs.sv
`default_nettype none
`include "vsk_consts.svh"
module vsk_sprite_regs (
    input  wire logic                clk,              // 50 MHz pipe clock
    input  wire logic                rst_n,            // async reset, active low
    input  wire logic                mmio_wr,          // register write strobe
    input  wire logic                mmio_rd,          // register read strobe
    input  wire logic [19:0]         mmio_addr,        // register byte address
    input  wire logic [31:0]         mmio_wdata,       // write data
    output logic      [31:0]         mmio_rdata,       // read data
    output logic                     mmio_rvalid,      // read data valid pulse
    input  wire logic                cs_flip,          // command streamer flip strobe
    input  wire logic [31:0]         cs_flip_base,     // flip surface base
    input  wire logic                vblank_start,     // start of vertical blank pulse
    input  wire logic                pipe_enable,      // pipe enabled level
    input  wire logic                sprite_enable,    // sprite enabled level
    input  wire logic                tiled_surface,    // surface in tiled memory
    input  wire logic                rotate_180,       // 180 degree rotation
    input  wire logic                src_key_enable,   // source key function on
    input  wire logic                dst_key_enable,   // destination key function on
    input  wire logic [31:0]         linear_pan_offset,// linear panning byte offset
    input  wire logic                pix_valid,        // pixel pair valid
    input  wire vsk_pkg::vsk_pix_s   sprite_pix,       // sprite pixel
    input  wire vsk_pkg::vsk_pix_s   primary_pix,      // primary plane pixel
    output vsk_pkg::vsk_pix_s        out_pix,          // blended pixel
    output logic                     out_valid,        // blended pixel valid
    output logic                     src_key_hit,      // sprite pixel was source keyed
    output logic [11:0]              size_height_m1,   // active height minus one
    output logic [11:0]              size_width_m1,    // active width minus one
    output logic [19:0]              gtt_page_index,   // surface page into translation table
    output logic [11:0]              pan_x,            // tiled x start
    output logic [11:0]              pan_y,            // tiled y start
    output logic [31:0]              pan_linear,       // linear byte offset in use
    output logic                     pan_lower_right,  // offsets name the lower right corner
    output logic                     update_armed      // armed registers still pending
);

    vsk_pkg::vsk_regs_s     pend;
    vsk_pkg::vsk_regs_s     act;
    vsk_pkg::vsk_regs_s     next_pend;
    vsk_pkg::vsk_regs_s     next_act;
    logic                   armed;
    logic                   next_armed;
    logic [31:0]            next_rdata;
    logic                   next_rvalid;
    logic [11:0]            next_pan_x;
    logic [11:0]            next_pan_y;
    logic [31:0]            next_pan_linear;
    logic                   next_lower_right;
    vsk_pkg::vsk_pix_s      next_out_pix;
    vsk_pkg::vsk_pix_s      key_pix;
    logic                   next_out_valid;
    logic                   next_src_hit;
    logic                   k_src_hit;
    logic                   k_dst_hit;
    logic                   surf_wr;
    logic                   upd_now;
    logic                   size_upd;
    vsk_pkg::vsk_key_mode_e key_mode;

    assign surf_wr  = (mmio_wr && (mmio_addr == `VSK_OFF_SURF)) || cs_flip;
    assign upd_now  = vblank_start || !pipe_enable;
    assign size_upd = armed && (upd_now || !sprite_enable);

    always_comb
    begin
        if (dst_key_enable)
            key_mode = vsk_pkg::VSK_KEY_DST;
        else if (src_key_enable)
            key_mode = vsk_pkg::VSK_KEY_SRC;
        else
            key_mode = vsk_pkg::VSK_KEY_OFF;
    end

    vsk_key_unit u_key (
        .mode        (key_mode),
        .key_min     (act.key_min),
        .key_mask    (act.key_mask),
        .key_max     (act.key_max),
        .sprite_pix  (sprite_pix),
        .primary_pix (primary_pix),
        .src_hit     (k_src_hit),
        .dst_hit     (k_dst_hit),
        .out_pix     (key_pix)
    );

    // register file: pending copies, active copies, read port
    always_comb
    begin
        next_pend   = pend;
        next_act    = act;
        next_armed  = armed;
        next_rdata  = 32'h00000000;
        next_rvalid = mmio_rd;
        if (mmio_wr)
        begin
            case (mmio_addr)
                `VSK_OFF_SIZE:     next_pend.size     = mmio_wdata & `VSK_MASK_SIZE;
                `VSK_OFF_KEY_MIN:  next_pend.key_min  = mmio_wdata & `VSK_MASK_KEY_MIN;
                `VSK_OFF_KEY_MASK: next_pend.key_mask = mmio_wdata & `VSK_MASK_KEY_MSK;
                `VSK_OFF_SURF:     next_pend.surf     = mmio_wdata & `VSK_MASK_SURF;
                `VSK_OFF_KEY_MAX:  next_pend.key_max  = mmio_wdata & `VSK_MASK_KEY_MAX;
                `VSK_OFF_TILE:     next_pend.tile     = mmio_wdata & `VSK_MASK_TILE;
                default:           next_pend          = pend;
            endcase
        end
        // a flip that lands with a register write wins the surface
        if (cs_flip)
            next_pend.surf = cs_flip_base & `VSK_MASK_SURF;
        if (upd_now)
        begin
            next_act.key_min  = pend.key_min;
            next_act.key_mask = pend.key_mask;
            next_act.surf     = pend.surf;
            next_act.key_max  = pend.key_max;
            next_act.tile     = pend.tile;
        end
        if (size_upd)
        begin
            next_act.size = pend.size;
            next_armed    = 1'b0;
        end
        // a new arm in the transfer cycle survives the clear
        if (surf_wr)
            next_armed = 1'b1;
        if (mmio_rd)
        begin
            case (mmio_addr)
                `VSK_OFF_SIZE:     next_rdata = pend.size;
                `VSK_OFF_KEY_MIN:  next_rdata = pend.key_min;
                `VSK_OFF_KEY_MASK: next_rdata = pend.key_mask;
                `VSK_OFF_SURF:     next_rdata = pend.surf;
                `VSK_OFF_KEY_MAX:  next_rdata = pend.key_max;
                `VSK_OFF_TILE:     next_rdata = pend.tile;
                `VSK_OFF_STATUS:   next_rdata = {31'h0, armed};
                default:           next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend        <= '{default: `VSK_RST_REG};
            act         <= '{default: `VSK_RST_REG};
            armed       <= 1'b0;
            mmio_rdata  <= 32'h00000000;
            mmio_rvalid <= 1'b0;
        end
        else
        begin
            pend        <= next_pend;
            act         <= next_act;
            armed       <= next_armed;
            mmio_rdata  <= next_rdata;
            mmio_rvalid <= next_rvalid;
        end
    end

    // panning start selection
    always_comb
    begin
        if (tiled_surface)
        begin
            next_pan_x       = act.tile[`VSK_LO_MSB:`VSK_LO_LSB];
            next_pan_y       = act.tile[`VSK_HI_MSB:`VSK_HI_LSB];
            next_pan_linear  = 32'h00000000;
            next_lower_right = rotate_180;
        end
        else
        begin
            next_pan_x       = 12'h000;
            next_pan_y       = 12'h000;
            next_pan_linear  = linear_pan_offset;
            next_lower_right = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pan_x           <= 12'h000;
            pan_y           <= 12'h000;
            pan_linear      <= 32'h00000000;
            pan_lower_right <= 1'b0;
        end
        else
        begin
            pan_x           <= next_pan_x;
            pan_y           <= next_pan_y;
            pan_linear      <= next_pan_linear;
            pan_lower_right <= next_lower_right;
        end
    end

    // pixel keying stage
    always_comb
    begin
        next_out_valid = pix_valid;
        next_out_pix   = pix_valid ? key_pix : out_pix;
        next_src_hit   = pix_valid && k_src_hit;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_pix     <= '0;
            out_valid   <= 1'b0;
            src_key_hit <= 1'b0;
        end
        else
        begin
            out_pix     <= next_out_pix;
            out_valid   <= next_out_valid;
            src_key_hit <= next_src_hit;
        end
    end

    assign size_height_m1 = act.size[`VSK_HI_MSB:`VSK_HI_LSB];
    assign size_width_m1  = act.size[`VSK_LO_MSB:`VSK_LO_LSB];
    assign gtt_page_index = act.surf[31:`VSK_PAGE_LSB];
    assign update_armed   = armed;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // key match restated from the active registers
    logic dst_match_chk;
    assign dst_match_chk = ((primary_pix ^ act.key_min[23:0]) & act.key_mask[23:0]) == 24'h000000;

    sequence s_surf_write;
        mmio_wr && (mmio_addr == `VSK_OFF_SURF) && !cs_flip;
    endsequence

    sequence s_clean_update;
        armed && vblank_start && !surf_wr;
    endsequence

    AST_ARM_ON_SURF: assert property (s_surf_write |=> armed && pend.surf == ($past(mmio_wdata) & `VSK_MASK_SURF))
        else $error("surface write did not arm");

    AST_SIZE_AFTER_ARM: assert property (s_clean_update |=> act.size == $past(pend.size) && !armed)
        else $error("armed size not transferred at vblank");

    AST_SIZE_HOLD: assert property (!armed |=> act.size == $past(act.size))
        else $error("size changed without arming");

    AST_KEY_UPDATE: assert property (upd_now |=> act.key_min == $past(pend.key_min)
                                      && act.key_max == $past(pend.key_max))
        else $error("key registers not updated at update point");

    AST_KEY_HOLD: assert property (pipe_enable && !vblank_start |=> $stable(act.key_mask) && $stable(act.tile))
        else $error("key mask or tile offset changed outside update point");

    AST_MAX_RSV: assert property (mmio_rd && mmio_addr == `VSK_OFF_KEY_MAX |=> mmio_rvalid && mmio_rdata[31:24] == 8'h00)
        else $error("key max reserved bits not zero");

    AST_SURF_RSV: assert property (mmio_rd && mmio_addr == `VSK_OFF_SURF |=> mmio_rdata[11:0] == 12'h000)
        else $error("surface low bits not zero");

    AST_FLIP_WRITE: assert property (cs_flip |=> armed && pend.surf == ($past(cs_flip_base) & `VSK_MASK_SURF))
        else $error("flip did not load surface base");

    AST_LINEAR_IGNORES_TILE: assert property (!tiled_surface |=> pan_x == 12'h000 && pan_y == 12'h000
                                               && pan_linear == $past(linear_pan_offset))
        else $error("linear surface panned from tile offset");

    AST_TILED_PAN: assert property (tiled_surface |=> {4'h0, pan_y, 4'h0, pan_x} == $past(act.tile))
        else $error("tiled pan not taken from tile offset");

    AST_DST_KEY: assert property (pix_valid && dst_key_enable |=>
                                   out_pix == ($past(dst_match_chk) ? $past(sprite_pix) : $past(primary_pix)))
        else $error("destination key selection wrong");

    AST_KEY_OFF: assert property (pix_valid && !dst_key_enable && !src_key_enable |=>
                                   out_pix == $past(sprite_pix) && !src_key_hit)
        else $error("keying active while disabled");

    AST_SRC_RANGE: assert property (pix_valid && src_key_enable && !dst_key_enable && act.key_mask[24]
                                     && sprite_pix.u > act.key_max[7:0] |=> !src_key_hit)
        else $error("out of range pixel was source keyed");

    AST_SRC_BELOW: assert property (pix_valid && src_key_enable && !dst_key_enable && act.key_mask[26]
                                    && sprite_pix.v < act.key_min[23:16] |=> !src_key_hit)
        else $error("pixel below minimum was source keyed");

    AST_MSK_RSV: assert property (mmio_rd && mmio_addr == `VSK_OFF_KEY_MASK |=>
                                  mmio_rdata[31:27] == 5'h00)
        else $error("key mask reserved bits not zero");

    AST_TILE_RSV: assert property (mmio_rd && mmio_addr == `VSK_OFF_TILE |=> mmio_rdata[31:28] == 4'h0
                                   && mmio_rdata[15:12] == 4'h0)
        else $error("tile offset reserved bits not zero");

    AST_SIZE_RSV: assert property (mmio_rd && mmio_addr == `VSK_OFF_SIZE |=> mmio_rdata[31:28] == 4'h0
                                   && mmio_rdata[15:12] == 4'h0)
        else $error("size reserved bits not zero");

    AST_STATUS: assert property (mmio_rd && mmio_addr == `VSK_OFF_STATUS |=>
                                 mmio_rdata == {31'h0, $past(armed)})
        else $error("status does not show arm flag");

    AST_ARM_HOLD: assert property (armed && !upd_now && sprite_enable |=> armed)
        else $error("arm lost before update point");

    AST_ARM_CLEAR: assert property (armed && (upd_now || !sprite_enable) && !surf_wr |=> !armed)
        else $error("arm not cleared after transfer");

    AST_ACT_UPDATE: assert property (upd_now |=> act.surf == $past(pend.surf)
                                     && act.tile == $past(pend.tile) && act.key_mask == $past(pend.key_mask))
        else $error("surface or tile not updated at update point");

    AST_ACT_HOLD: assert property (pipe_enable && !vblank_start |=> $stable(act.key_min)
                                   && $stable(act.key_max) && $stable(act.surf))
        else $error("key or surface changed outside update point");

    AST_LOWER_RIGHT: assert property (tiled_surface && rotate_180 |=> pan_lower_right)
        else $error("rotated tiled pan not flagged");

    AST_DST_NO_SRC: assert property (pix_valid && dst_key_enable |=> !src_key_hit)
        else $error("source hit in destination mode");

endmodule
`default_nettype wire

//--- sim/vsk_host_model.sv
`default_nettype none
`include "vsk_consts.svh"
module vsk_host_model (
    input  wire logic        clk,          // pipe clock
    output logic             mmio_wr,      // write strobe
    output logic             mmio_rd,      // read strobe
    output logic [19:0]      mmio_addr,    // register address
    output logic [31:0]      mmio_wdata,   // write data
    output logic             cs_flip,      // flip strobe
    output logic [31:0]      cs_flip_base  // flip base address
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        mmio_wr = 1'b0;
        mmio_rd = 1'b0;
        mmio_addr = 20'h00000;
        mmio_wdata = 32'h00000000;
        cs_flip = 1'b0;
        cs_flip_base = 32'h00000000;
    end

    // software only hands over legal values
    task automatic wr(input logic [19:0] a, input logic [31:0] d, output logic [31:0] sent);
        sent = d;
        if (a == `VSK_OFF_SURF)
            sent[11:0] = 12'h000;
        if (a == `VSK_OFF_SIZE)
            sent[0] = 1'b1;
        if (a == `VSK_OFF_TILE)
            sent[0] = 1'b0;
        @(negedge clk);
        mmio_wr = 1'b1;
        mmio_addr = a;
        mmio_wdata = sent;
        @(negedge clk);
        mmio_wr = 1'b0;
        mmio_wdata = ~sent;
        mmio_addr = ~a;
    endtask

    task automatic rd(input logic [19:0] a);
        @(negedge clk);
        mmio_rd = 1'b1;
        mmio_addr = a;
        @(negedge clk);
        mmio_rd = 1'b0;
        mmio_addr = ~a;
    endtask

    task automatic flip(input logic [31:0] b);
        @(negedge clk);
        cs_flip = 1'b1;
        cs_flip_base = {b[31:12], 12'h000};
        @(negedge clk);
        cs_flip = 1'b0;
        cs_flip_base = ~cs_flip_base;
    endtask
endmodule
`default_nettype wire

//--- sim/vsk_sprite_regs_tb.sv
`default_nettype none
`include "vsk_consts.svh"
`define VSK_CHK(nm, ex, got) \
    begin \
        samples_checked++; \
        if ((got) !== (ex)) \
        begin \
            n_fail++; \
            $display("wrong value %s expected %h seen %h", nm, ex, got); \
        end \
    end
module vsk_sprite_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [19:0] OFFS [6] = '{`VSK_OFF_SIZE, `VSK_OFF_KEY_MIN, `VSK_OFF_KEY_MASK,
                                         `VSK_OFF_SURF, `VSK_OFF_KEY_MAX, `VSK_OFF_TILE};
    localparam logic [31:0] MSKS [6] = '{`VSK_MASK_SIZE, `VSK_MASK_KEY_MIN, `VSK_MASK_KEY_MSK,
                                         `VSK_MASK_SURF, `VSK_MASK_KEY_MAX, `VSK_MASK_TILE};

    logic                clk;
    logic                rst_n;
    logic                mmio_wr;
    logic                mmio_rd;
    logic [19:0]         mmio_addr;
    logic [31:0]         mmio_wdata;
    logic [31:0]         mmio_rdata;
    logic                mmio_rvalid;
    logic                cs_flip;
    logic [31:0]         cs_flip_base;
    logic                vblank_start;
    logic                pipe_enable;
    logic                sprite_enable;
    logic                tiled_surface;
    logic                rotate_180;
    logic                src_key_enable;
    logic                dst_key_enable;
    logic [31:0]         linear_pan_offset;
    logic                pix_valid;
    vsk_pkg::vsk_pix_s   sprite_pix;
    vsk_pkg::vsk_pix_s   primary_pix;
    vsk_pkg::vsk_pix_s   out_pix;
    logic                out_valid;
    logic                src_key_hit;
    logic [11:0]         size_height_m1;
    logic [11:0]         size_width_m1;
    logic [19:0]         gtt_page_index;
    logic [11:0]         pan_x;
    logic [11:0]         pan_y;
    logic [31:0]         pan_linear;
    logic                pan_lower_right;
    logic                update_armed;
    int                  n_fail = 0;
    int                  samples_checked = 0;
    integer              seed = 32'hA20196DE;
    logic [31:0]         q_rd [$];
    logic [24:0]         q_pix [$];

    vsk_sprite_regs u_dut (
        .clk(clk), .rst_n(rst_n), .mmio_wr(mmio_wr), .mmio_rd(mmio_rd), .mmio_addr(mmio_addr),
        .mmio_wdata(mmio_wdata), .mmio_rdata(mmio_rdata), .mmio_rvalid(mmio_rvalid), .cs_flip(cs_flip),
        .cs_flip_base(cs_flip_base), .vblank_start(vblank_start), .pipe_enable(pipe_enable),
        .sprite_enable(sprite_enable), .tiled_surface(tiled_surface), .rotate_180(rotate_180),
        .src_key_enable(src_key_enable), .dst_key_enable(dst_key_enable), .linear_pan_offset(linear_pan_offset),
        .pix_valid(pix_valid), .sprite_pix(sprite_pix), .primary_pix(primary_pix), .out_pix(out_pix),
        .out_valid(out_valid), .src_key_hit(src_key_hit), .size_height_m1(size_height_m1),
        .size_width_m1(size_width_m1), .gtt_page_index(gtt_page_index), .pan_x(pan_x), .pan_y(pan_y),
        .pan_linear(pan_linear), .pan_lower_right(pan_lower_right), .update_armed(update_armed)
    );

    vsk_host_model u_host (
        .clk          (clk),
        .mmio_wr      (mmio_wr),
        .mmio_rd      (mmio_rd),
        .mmio_addr    (mmio_addr),
        .mmio_wdata   (mmio_wdata),
        .cs_flip      (cs_flip),
        .cs_flip_base (cs_flip_base)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // expected {hit, pixel} for one pixel pair
    function automatic logic [24:0] ref_pix(input int m, input logic [31:0] kmin, kmsk, kmax,
                                            input logic [23:0] s, p);
        logic hit;
        hit = 1'b1;
        if (m == 2)
            return {1'b0, (((p ^ kmin[23:0]) & kmsk[23:0]) == 24'h000000) ? s : p};
        if (m == 0)
            return {1'b0, s};
        for (int c = 0; c < 3; c++)
            if (kmsk[24 + c] && (s[8*c +: 8] < kmin[8*c +: 8] || s[8*c +: 8] > kmax[8*c +: 8]))
                hit = 1'b0;
        return {hit, hit ? p : s};
    endfunction

    task automatic rdchk(input logic [19:0] a, input logic [31:0] e);
        q_rd.push_back(e);
        u_host.rd(a);
    endtask

    task automatic pulse_vblank();
        @(negedge clk);
        vblank_start = 1'b1;
        @(negedge clk);
        vblank_start = 1'b0;
    endtask

    task automatic results();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // results arrive one cycle after their request; taken at the falling edge
    initial
    forever
    begin
        @(negedge clk);
        if (mmio_rvalid === 1'b1)
            `VSK_CHK("mmio_rdata", q_rd.pop_front(), mmio_rdata)
        if (out_valid === 1'b1)
            `VSK_CHK("out_pix", q_pix.pop_front(), {src_key_hit, out_pix})
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail++;
        results();
    end

    initial
    begin
        logic [31:0] d, sent, sz, kmin, kmsk, kmax;
        logic [23:0] s, p;
        {rst_n, vblank_start, pix_valid, tiled_surface, rotate_180} = 5'h00;
        {pipe_enable, sprite_enable, src_key_enable, dst_key_enable} = 4'h C;
        linear_pan_offset = 32'h00000000;
        sprite_pix = 24'h000000;
        primary_pix = 24'h000000;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 6; i++)
            rdchk(OFFS[i], `VSK_RST_REG);
        rdchk(`VSK_OFF_STATUS, 32'h00000000);
        for (int i = 0; i < 6; i++)
        begin
            u_host.wr(OFFS[i], $random(seed), sent);
            rdchk(OFFS[i], sent & MSKS[i]);
            if (i == 0)
                sz = sent;
            if (i == 3)
                d = sent;
        end
        u_host.wr(20'h72204, $random(seed), sent);
        rdchk(20'h72204, 32'h00000000);
        rdchk(`VSK_OFF_STATUS, 32'h00000001);
        `VSK_CHK("size_width_m1", 12'h000, size_width_m1)
        pulse_vblank();
        `VSK_CHK("size_height_m1", sz[27:16], size_height_m1)
        `VSK_CHK("size_width_m1", sz[11:0], size_width_m1)
        `VSK_CHK("update_armed", 1'b0, update_armed)
        `VSK_CHK("gtt_page_index", d[31:12], gtt_page_index)
        u_host.wr(`VSK_OFF_SIZE, $random(seed), sent);
        pulse_vblank();
        `VSK_CHK("size_width_m1", sz[11:0], size_width_m1)
        u_host.wr(`VSK_OFF_SURF, $random(seed), sz);
        @(negedge clk);
        sprite_enable = 1'b0;
        @(negedge clk);
        sprite_enable = 1'b1;
        `VSK_CHK("size_width_m1", sent[11:0], size_width_m1)
        `VSK_CHK("gtt_page_index", d[31:12], gtt_page_index)
        u_host.flip($random(seed));
        `VSK_CHK("update_armed", 1'b1, update_armed)
        d = u_host.cs_flip_base;
        @(negedge clk);
        pipe_enable = 1'b0;
        @(negedge clk);
        pipe_enable = 1'b1;
        `VSK_CHK("gtt_page_index", ~d[31:12], gtt_page_index)
        u_host.wr(`VSK_OFF_TILE, $random(seed), sent);
        linear_pan_offset = $random(seed);
        tiled_surface = 1'b1;
        rotate_180 = 1'b1;
        pulse_vblank();
        repeat (3) @(negedge clk);
        `VSK_CHK("pan_y", sent[27:16], pan_y)
        `VSK_CHK("pan_x", sent[11:0], pan_x)
        `VSK_CHK("pan_lower_right", 1'b1, pan_lower_right)
        `VSK_CHK("pan_linear", 32'h00000000, pan_linear)
        tiled_surface = 1'b0;
        repeat (3) @(negedge clk);
        `VSK_CHK("pan_xy", 24'h000000, {pan_y, pan_x})
        `VSK_CHK("pan_linear", linear_pan_offset, pan_linear)
        `VSK_CHK("pan_lower_right", 1'b0, pan_lower_right)
        for (int m = 0; m < 3; m++)
        begin
            kmin = (m == 1) ? 32'h00303030 : $random(seed) & 32'h00FFFFFF;
            kmax = 32'h00D0D0D0;
            // source mode leaves the destination mask bits zero
            kmsk = (m == 1) ? 32'h05000000 : $random(seed) & 32'h00FFFFFF;
            u_host.wr(`VSK_OFF_KEY_MIN, kmin, sent);
            u_host.wr(`VSK_OFF_KEY_MASK, kmsk, sent);
            u_host.wr(`VSK_OFF_KEY_MAX, kmax, sent);
            pulse_vblank();
            src_key_enable = (m == 1);
            dst_key_enable = (m == 2);
            for (int i = 0; i < 16; i++)
            begin
                @(negedge clk);
                s = $random(seed);
                p = $random(seed);
                if (i[0])
                    p = (kmin[23:0] & kmsk[23:0]) | (p & ~kmsk[23:0]);
                pix_valid = 1'b1;
                sprite_pix = s;
                primary_pix = p;
                q_pix.push_back(ref_pix(m, kmin, kmsk, kmax, s, p));
            end
            @(negedge clk);
            pix_valid = 1'b0;
        end
        repeat (3) @(negedge clk);
        `VSK_CHK("queues_left", 0, q_rd.size() + q_pix.size())
        results();
    end
endmodule
`default_nettype wire
